// *** hw/burst_sram_pkg.sv ***
// Purpose: shared constants and types for the pipelined burst memory control
// Assumes: single rising-edge clock at 200 MHz
// Notes: organisation of 128K words, four byte lanes of nine bits
package burst_sram_pkg;
   localparam int ADDR_W = 17;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int DATA_W = LANES * LANE_W;
   localparam int WORDS = 131072;
   localparam int CLK_MHZ = 200;
   localparam int SLEEP_ENTER_CYC = 2;
   localparam int WAKE_CYC = 2;
   localparam logic [3:0] LANES_ALL = 4'hf;
   localparam logic [1:0] SLEEP_CNT_RST = 2'h0;
   localparam int BURST_LO = 0;
   localparam int BURST_HI = 1;
   typedef enum logic [1:0] {
      OP_IDLE = 2'b00,
      OP_READ = 2'b01,
      OP_WRITE = 2'b10
   } op_t;
endpackage : burst_sram_pkg

// *** hw/burst_ctl_if.sv ***
// Purpose: carries burst counter controls between the decode and the counter
// Assumes: one clock domain
// Notes: none
interface burst_ctl_if;
   logic load;
   logic step;
   logic interleave;
   logic [1:0] start;
   logic [1:0] low_addr;
   modport ctl (output load, output step, output interleave, output start, input low_addr);
   modport cnt (input load, input step, input interleave, input start, output low_addr);
endinterface : burst_ctl_if

// *** hw/burst_counter.sv ***
// Purpose: two-bit burst address counter, linear or interleaved
// Assumes: load has priority over step
// Notes: wraps to the start value after the fourth access
module burst_counter (
   input wire logic clock,
   input wire logic nrst,
   burst_ctl_if.cnt bc
);
   typedef struct packed {
      logic [1:0] start;
      logic [1:0] cnt;
   } cnt_state_t;
   cnt_state_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (bc.load) begin
         s_d.start = bc.start;
         s_d.cnt = 2'h0;
      end else if (bc.step) begin
         // R18: counter wraps
         s_d.cnt = 2'(s_q.cnt + 2'h1);
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // R17: linear or xor order
   assign bc.low_addr = bc.interleave ? (s_q.start ^ s_q.cnt) : 2'(s_q.start + s_q.cnt);

   property p_wrap;
      @(posedge clock) disable iff (!nrst)
         (bc.load ##1 (!bc.load && bc.step)[*4]) |=> bc.low_addr == $past(bc.low_addr, 4);
   endproperty
   // R18: four steps return start
   a_wrap: assert property (p_wrap) else $error("burst did not wrap"); // R18
endmodule : burst_counter

// *** hw/pipelined_burst_sram_control.sv ***
// Purpose: cycle decode, burst control, write decode and output pipeline
// Assumes: all pins synchronous; nrst only for simulation start
// Notes: data pins split into in, out and output enable
// Operation
// R1: processor strobe with selects starts burst read, writes ignored
// R2: controller strobe alone with selects starts write or read by write decode
// R3: no new address, step low, no write: continue read
// R4: no new address, step low, write: continue write
// R5: no new address, step high, no write: suspend read, hold address
// R6: no new address, step high, write: suspend write, hold address
// R7: strobe low with any select inactive deselects; controller keeps selects; code ignores a processor strobe with primary select high
// R8: global write writes all lanes; else gated lane strobes pick lanes
// R9: read when global write high and gate high or all strobes high
// R10: sleep and output enable qualify drive; drive only on read
// R11: sleep high tristates pins and powers down
// R12: deselect or write never drives data pins; code still drives the prior read's data on the edge of a deselect
// R13: controller drops output enable before write after read
// R14: power down within two cycles of sleep rising
// R15: controller waits two cycles after wake before any strobe
// R16: two devices on opposite select polarity double depth
// R17: linear burst order when order pin low, interleaved when high
// R18: counter starts at external low bits and wraps after four
// R19: read data passes output register then output buffer
// R20: step input ignored on processor strobe edge
module pipelined_burst_sram_control #(
   parameter int ADDR_W = burst_sram_pkg::ADDR_W,
   parameter int LANES = burst_sram_pkg::LANES,
   parameter int LANE_W = burst_sram_pkg::LANE_W
) (
   input wire logic clock,
   input wire logic nrst,
   // address and strobes
   input wire logic [ADDR_W-1:0] addr,
   input wire logic processor_addr_strobe_n,
   input wire logic controller_addr_strobe_n,
   input wire logic burst_step_n,
   // selects
   input wire logic primary_select_n,
   input wire logic high_true_select,
   input wire logic second_low_true_select_n,
   // write control
   input wire logic global_write_n,
   input wire logic byte_write_gate_n,
   input wire logic [LANES-1:0] lane_write_strobes_n,
   // output enable, sleep and static order controls, all sampled on the clock
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic burst_order_select,
   // data pins
   input wire logic [LANES*LANE_W-1:0] dq_in,
   output logic [LANES*LANE_W-1:0] dq_out,
   output logic [LANES*LANE_W-1:0] dq_oe,
   // status
   output logic powered_down
);
   localparam int DW = LANES * LANE_W;
   localparam int DEPTH = 1 << ADDR_W;

   typedef struct packed {
      logic [ADDR_W-3:0] hi_addr;
      burst_sram_pkg::op_t op;
      logic sel;
      logic [1:0] sleep_cnt;
      logic [1:0] wake_cnt;
      logic pdown;
      logic rd_s1;
      logic rd_s2;
      logic [DW-1:0] out_reg;
      logic [DW-1:0] out_buf;
      logic [DW-1:0] dq_out;
      logic [DW-1:0] dq_oe;
   } state_t;
   state_t s_q, s_d;

   logic [DW-1:0] mem [DEPTH];
   burst_ctl_if bc ();

   burst_counter u_cnt (
      .clock(clock),
      .nrst(nrst),
      .bc(bc.cnt)
   );

   function automatic logic [LANES-1:0] lane_decode(
      input logic gw_n, input logic bw_n, input logic [LANES-1:0] we_n);
      if (!gw_n) lane_decode = {LANES{1'b1}};
      else if (!bw_n) lane_decode = ~we_n;
      else lane_decode = '0;
   endfunction

   logic [LANES-1:0] lanes;
   logic wr_req, all_sel, ps_start, cs_start, deselect, cur_sel, cont;
   logic [ADDR_W-1:0] cur_addr;

   always_comb begin
      // R8: lane decode
      lanes = lane_decode(global_write_n, byte_write_gate_n, lane_write_strobes_n);
      // R9: read when no lane
      wr_req = |lanes;
      all_sel = !primary_select_n && high_true_select && !second_low_true_select_n;
      // R1: processor strobe start
      ps_start = all_sel && !processor_addr_strobe_n && !s_q.pdown;
      // R2: controller strobe start
      cs_start = all_sel && processor_addr_strobe_n && !controller_addr_strobe_n
                 && !s_q.pdown;
      // R7: deselect edge; a blocked processor strobe alone is no deselect
      deselect = (!controller_addr_strobe_n || (!processor_addr_strobe_n
                 && !primary_select_n)) && !all_sel;
      cur_sel = s_q.sel;
      // continue edges are the only ones that touch the array
      cont = cur_sel && !s_q.pdown && !ps_start && !cs_start && !deselect;
      cur_addr = {s_q.hi_addr, bc.low_addr};
   end

   always_comb begin
      s_d = s_q;
      bc.load = 1'b0;
      bc.step = 1'b0;
      bc.start = addr[1:0];
      bc.interleave = burst_order_select;
      // R14: enter power down after two cycles
      if (sleep_request) begin
         s_d.wake_cnt = 2'h0;
         if (s_q.sleep_cnt != 2'(burst_sram_pkg::SLEEP_ENTER_CYC - 1)) begin
            s_d.sleep_cnt = 2'(s_q.sleep_cnt + 2'h1);
         end else begin
            s_d.pdown = 1'b1;
         end
      end else begin
         s_d.sleep_cnt = burst_sram_pkg::SLEEP_CNT_RST;
         if (s_q.pdown) begin
            if (s_q.wake_cnt != 2'(burst_sram_pkg::WAKE_CYC - 1)) begin
               s_d.wake_cnt = 2'(s_q.wake_cnt + 2'h1);
            end else begin
               s_d.pdown = 1'b0;
            end
         end
      end
      s_d.rd_s1 = 1'b0;
      if (ps_start) begin
         // R1: read, writes ignored
         bc.load = 1'b1;
         s_d.hi_addr = addr[ADDR_W-1:2];
         s_d.op = burst_sram_pkg::OP_READ;
         s_d.sel = 1'b1;
      end else if (cs_start) begin
         // R2: write or read by decode
         bc.load = 1'b1;
         s_d.hi_addr = addr[ADDR_W-1:2];
         s_d.op = wr_req ? burst_sram_pkg::OP_WRITE : burst_sram_pkg::OP_READ;
         s_d.sel = 1'b1;
      end else if (deselect) begin
         s_d.sel = 1'b0;
         s_d.op = burst_sram_pkg::OP_IDLE;
      end else if (cur_sel && !s_q.pdown) begin
         // R20: step sampled only after start edge
         s_d.op = wr_req ? burst_sram_pkg::OP_WRITE : burst_sram_pkg::OP_READ;
         // R3: R4: advance on step low; R5: R6: hold
         bc.step = !burst_step_n;
      end
      // each continue edge reads or writes by its own write decode
      if (cont && !wr_req) begin
         // R19: output register stage
         s_d.out_reg = mem[cur_addr];
         s_d.rd_s1 = 1'b1;
      end
      // R19: output buffer stage
      s_d.out_buf = s_q.out_reg;
      s_d.rd_s2 = s_q.rd_s1;
      s_d.dq_out = s_q.out_reg;
      // R10: R11: R12: drive only for read, awake, oe low
      s_d.dq_oe = {DW{s_q.rd_s1 && !sleep_request && !s_d.pdown && !output_enable_n
                  && !(cont && wr_req)}};
   end

   // write into the array; data pins sampled with the write controls
   always_ff @(posedge clock) begin
      for (int i = 0; i < LANES; i++) begin
         // R8: lane write
         if (cont && lanes[i]) begin
            mem[cur_addr][i*LANE_W +: LANE_W] <= dq_in[i*LANE_W +: LANE_W];
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign dq_out = s_q.dq_out;
   assign dq_oe = s_q.dq_oe;
   assign powered_down = s_q.pdown;

   sequence s_sleep_held;
      sleep_request [*2];
   endsequence
   property p_sleep_enter;
      @(posedge clock) disable iff (!nrst) s_sleep_held |=> powered_down;
   endproperty
   a_sleep_enter: assert property (p_sleep_enter) else $error("no power down"); // R14
   property p_sleep_z;
      @(posedge clock) disable iff (!nrst) sleep_request |=> dq_oe == '0;
   endproperty
   a_sleep_z: assert property (p_sleep_z) else $error("driving in sleep"); // R11
   property p_oe_z;
      @(posedge clock) disable iff (!nrst) output_enable_n |=> dq_oe == '0;
   endproperty
   a_oe_z: assert property (p_oe_z) else $error("driving with oe high"); // R10
   property p_desel;
      @(posedge clock) disable iff (!nrst) deselect |=> !s_q.sel;
   endproperty
   a_desel: assert property (p_desel) else $error("deselect missed"); // R7
   property p_ps_read;
      @(posedge clock) disable iff (!nrst) ps_start |=> s_q.op == burst_sram_pkg::OP_READ;
   endproperty
   a_ps_read: assert property (p_ps_read) else $error("processor start not read"); // R1
   property p_cs_write;
      @(posedge clock) disable iff (!nrst)
         (cs_start && wr_req) |=> s_q.op == burst_sram_pkg::OP_WRITE;
   endproperty
   a_cs_write: assert property (p_cs_write) else $error("controller write missed"); // R2
   property p_hold;
      @(posedge clock) disable iff (!nrst)
         (cur_sel && !ps_start && !cs_start && !deselect && burst_step_n)
         |=> $stable(bc.low_addr);
   endproperty
   a_hold: assert property (p_hold) else $error("suspend moved address"); // R5
   property p_gw;
      @(posedge clock) disable iff (!nrst) !global_write_n |-> lanes == {LANES{1'b1}};
   endproperty
   a_gw: assert property (p_gw) else $error("global write lanes"); // R8
   property p_pipe;
      @(posedge clock) disable iff (!nrst)
         s_q.rd_s1 |=> s_q.rd_s2 && s_q.out_buf == $past(s_q.out_reg);
   endproperty
   a_pipe: assert property (p_pipe) else $error("pipeline stage"); // R19
endmodule : pipelined_burst_sram_control

// *** dv/cache_ctl_model.sv ***
// Purpose: far-side cache controller model that drives the memory pins
// Assumes: pins change just after the rising edge and hold for one cycle
// Notes: data lines carry fresh noise whenever no write is under way
module cache_ctl_model (
   // clock
   input wire logic clock,
   // pins toward the memory
   output logic [burst_sram_pkg::ADDR_W-1:0] addr,
   output logic proc_n,
   output logic ctrl_n,
   output logic step_n,
   output logic [2:0] sel,
   output logic gw_n,
   output logic bw_n,
   output logic [3:0] we_n,
   output logic oe_n,
   output logic zz,
   output logic order,
   output logic [burst_sram_pkg::DATA_W-1:0] dq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic oe_u = 1'b0;
   logic zz_u = 1'b0;
   logic ord_u = 1'b0;
   int quiet = 3;
   initial begin
      {proc_n, ctrl_n, step_n, gw_n, bw_n, oe_n, zz, order} = 8'hfc;
      {we_n, sel, addr, dq} = {4'hf, 3'b010, 53'h0};
   end
   task cyc(input logic p, c, s, g, b, input logic [3:0] w, input logic [2:0] cs,
      input logic [16:0] a, input logic [35:0] d);
      @(posedge clock);
      {proc_n, ctrl_n, step_n, gw_n, bw_n, we_n, sel, addr, dq} <= {p, c, s, g, b, w, cs, a, d};
      oe_n <= oe_u | !g | (!b && w != 4'hf);
      zz <= zz_u;
      order <= ord_u;
      quiet = zz_u ? 0 : quiet + 1;
   endtask
   task start(input logic p, input logic g, input logic [16:0] a, input logic [35:0] d);
      while (quiet < 3) cyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 3'b010, a, d);
      cyc(!p, p, 1'b0, g, 1'b1, 4'hf, 3'b010, a, d);
   endtask
endmodule // cache_ctl_model

// *** dv/pipelined_burst_sram_control_test.sv ***
// Purpose: self-checking bench comparing the control block with an associative-array model
// Assumes: reads of words never written are not compared
// Notes: two deselect cycles separate bursts so the pipeline drains between them
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
   $display("ERROR t=%0t got %h want %h", $time, g, e); end end
module pipelined_burst_sram_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   wire logic [burst_sram_pkg::ADDR_W-1:0] addr;
   wire logic processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n;
   wire logic primary_select_n, high_true_select, second_low_true_select_n;
   wire logic global_write_n, byte_write_gate_n, output_enable_n;
   wire logic sleep_request, burst_order_select;
   wire logic [3:0] lane_write_strobes_n;
   wire logic [burst_sram_pkg::DATA_W-1:0] dq_in;
   logic [burst_sram_pkg::DATA_W-1:0] dq_out, dq_oe;
   logic powered_down;
   int fails = 0;
   int compares = 0;
   logic [31:0] seed = 32'h4801;
   logic [35:0] mem [int];
   logic [16:0] base = 17'h0;
   logic [1:0] k = 2'h0;
   bit act = 1'b0;
   bit pv [2] = '{1'b0, 1'b0};
   bit pk [2] = '{1'b0, 1'b0};
   bit pe = 1'b0;
   logic [35:0] pd [2];
   logic [5:0] wtab [6] = '{6'h2e, 6'h2d, 6'h30, 6'h23, 6'h2f, 6'h20};
   always #2.5 clock = ~clock;
   cache_ctl_model FAR (.clock(clock), .addr(addr), .proc_n(processor_addr_strobe_n),
      .ctrl_n(controller_addr_strobe_n), .step_n(burst_step_n),
      .sel({primary_select_n, high_true_select, second_low_true_select_n}),
      .gw_n(global_write_n), .bw_n(byte_write_gate_n), .we_n(lane_write_strobes_n),
      .oe_n(output_enable_n), .zz(sleep_request), .order(burst_order_select), .dq(dq_in));
   pipelined_burst_sram_control DUT (.clock, .nrst, .addr, .processor_addr_strobe_n,
      .controller_addr_strobe_n, .burst_step_n, .primary_select_n, .high_true_select,
      .second_low_true_select_n, .global_write_n, .byte_write_gate_n, .lane_write_strobes_n,
      .output_enable_n, .sleep_request, .burst_order_select, .dq_in, .dq_out, .dq_oe,
      .powered_down);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [35:0] dat();
      return {rnd(), 4'(rnd())};
   endfunction
   task beat(input logic s, g, b, input logic [3:0] w, input logic pb);
      FAR.cyc(!pb, 1'b1, s, g, b, w, {pb, 2'b10}, 17'(rnd()), dat());
   endtask
   task desel(input int n);
      logic [2:0] t [3];
      t = '{3'b110, 3'b000, 3'b011};
      FAR.cyc(n != 1, n == 1, 1'b1, 1'b1, 1'b1, 4'hf, t[n], 17'(rnd()), dat());
   endtask
   task finish_test();
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // reference: decode each sampled edge, expect data two edges later
   always @(posedge clock) begin : ref_model
      logic sel, stb, wr;
      logic [16:0] ca;
      logic [35:0] m;
      if (nrst) begin
         // the enable is registered from the edge after the read
         `CHK(dq_oe, {36{pe}})
         if (pv[1] && pk[1]) `CHK(dq_out, pd[1])
         pe = pv[0] & ~output_enable_n & ~sleep_request;
         pv[1] = pv[0];
         pk[1] = pk[0];
         pd[1] = pd[0];
         pv[0] = 1'b0;
         sel = !primary_select_n && high_true_select && !second_low_true_select_n;
         stb = !processor_addr_strobe_n || !controller_addr_strobe_n;
         wr = !global_write_n || (!byte_write_gate_n && lane_write_strobes_n != 4'hf);
         ca = {base[16:2], burst_order_select ? base[1:0] ^ k : base[1:0] + k};
         if (sleep_request || powered_down) begin
         end else if ((stb && !sel && !primary_select_n) ||
            (primary_select_n && !controller_addr_strobe_n)) begin
            act = 1'b0;
         end else if (sel && stb) begin
            base = addr;
            k = 2'h0;
            act = 1'b1;
         end else if (act) begin
            m = mem.exists(ca) ? mem[ca] : 'x;
            for (int i = 0; i < 4; i++)
               if (wr && (!global_write_n || !lane_write_strobes_n[i])) m[9*i+:9] = dq_in[9*i+:9];
            if (wr) mem[ca] = m;
            else begin
               pv[0] = 1'b1;
               pk[0] = mem.exists(ca);
               pd[0] = m;
            end
            if (!burst_step_n) k = k + 2'h1;
         end
      end
   end
   initial begin
      #20000;
      fails++;
      finish_test();
   end
   initial begin : main
      logic [16:0] a;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      for (int o = 0; o < 2; o++) begin
         for (int s = 0; s < 4; s++) begin
            a = {15'(rnd()), 2'(s)};
            FAR.ord_u = 1'b0;
            FAR.start(1'b0, 1'b0, a, dat());
            repeat (4) beat(1'b0, 1'b0, 1'b1, 4'hf, 1'b0);
            desel(0);
            desel(0);
            FAR.ord_u = 1'(o);
            // reads back linear on the first pass, interleaved on the second, wrapping past four beats
            FAR.start(o == 0, 1'(o), a, dat());
            for (int j = 0; j < 6; j++) beat(1'b0, 1'b1, 1'b1, 4'h0, 1'(j % 2));
            desel(s % 3);
            desel(0);
         end
      end
      FAR.ord_u = 1'b0;
      a = 17'(rnd());
      FAR.start(1'b0, 1'b0, a, dat());
      repeat (4) beat(1'b0, 1'b0, 1'b1, 4'hf, 1'b0);
      // lane patterns while suspended on one word
      foreach (wtab[i]) beat(1'b1, wtab[i][5], wtab[i][4], wtab[i][3:0], 1'b0);
      repeat (4) beat(1'b0, 1'b1, 1'b1, 4'hf, 1'b0);
      desel(1);
      desel(0);
      FAR.oe_u = 1'b1;
      FAR.start(1'b1, 1'b1, a, dat());
      repeat (4) beat(1'b0, 1'b1, 1'b1, 4'hf, 1'b0);
      desel(2);
      desel(0);
      FAR.oe_u = 1'b0;
      FAR.zz_u = 1'b1;
      repeat (4) beat(1'b1, 1'b1, 1'b1, 4'hf, 1'b0);
      #1 `CHK(powered_down, 1'b1)
      // a start while asleep must be refused
      FAR.cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 3'b010, a, dat());
      repeat (2) beat(1'b0, 1'b1, 1'b1, 4'hf, 1'b0);
      FAR.zz_u = 1'b0;
      FAR.start(1'b1, 1'b1, a, dat());
      repeat (4) beat(1'b0, 1'b1, 1'b1, 4'hf, 1'b0);
      desel(0);
      desel(0);
      repeat (2) @(posedge clock);
      finish_test();
   end
endmodule // pipelined_burst_sram_control_test
